// >>> rtl/exec_pkg.sv
package exec_pkg;
  // ==========================================================
  // register map (byte offsets)
  localparam logic [5:0] OFF_INSTR  = 6'h00;
  localparam logic [5:0] OFF_ACC    = 6'h04;
  localparam logic [5:0] OFF_STATUS = 6'h08;
  localparam logic [5:0] OFF_PC     = 6'h0C;
  localparam logic [5:0] OFF_ULATCH = 6'h10;
  localparam logic [5:0] OFF_STACK  = 6'h14;
  localparam logic [5:0] OFF_FADDR  = 6'h18;
  localparam logic [5:0] OFF_FDATA  = 6'h1C;
  localparam logic [5:0] OFF_WDOG   = 6'h20;
  // ==========================================================
  // status layout and reset values
  localparam int         STAT_STANDBY_BIT = 6;
  localparam logic [5:0] FLAGS_RST        = 6'h18;
  localparam int         ULATCH_HI        = 4;
  localparam int         ULATCH_LO        = 3;
  // ==========================================================
  // timing
  localparam int         WDOG_PRESC_DIV   = 256;
  // ==========================================================
  // opcode masks and matches
  localparam logic [13:0] M_HI8    = 14'h3F00;
  localparam logic [13:0] M_ALL    = 14'h3FFF;
  localparam logic [13:0] M_JUMP_ABSOLUTE   = 14'h3800;
  localparam logic [13:0] P_JUMP_ABSOLUTE   = 14'h2800;
  localparam logic [13:0] P_OR_LITERAL_ACC  = 14'h3800;
  localparam logic [13:0] P_XOR_LITERAL_ACC  = 14'h3A00;
  localparam logic [13:0] M_LOAD_LITERAL_ACC  = 14'h3C00;
  localparam logic [13:0] P_LOAD_LITERAL_ACC  = 14'h3000;
  localparam logic [13:0] P_RETURN_WITH_LITERAL  = 14'h3400;
  localparam logic [13:0] M_LITERAL_MINUS_ACC  = 14'h3E00;
  localparam logic [13:0] P_LITERAL_MINUS_ACC  = 14'h3C00;
  localparam logic [13:0] P_RETURN_IRQ = 14'h0009;
  localparam logic [13:0] P_RETURN = 14'h0008;
  localparam logic [13:0] P_SLEEP  = 14'h0063;
  localparam logic [13:0] M_STORE_ACC_REG  = 14'h3F80;
  localparam logic [13:0] P_STORE_ACC_REG  = 14'h0080;
  localparam logic [13:0] M_NOP    = 14'h3F9F;
  localparam logic [13:0] P_NOP    = 14'h0000;
  localparam logic [13:0] P_INCREMENT_REG   = 14'h0A00;
  localparam logic [13:0] P_OR_ACC_INTO_REG  = 14'h0400;
  localparam logic [13:0] P_COPY_REG   = 14'h0800;
  localparam logic [13:0] P_RLF    = 14'h0D00;
  localparam logic [13:0] P_RRF    = 14'h0C00;
  localparam logic [13:0] P_REG_MINUS_ACC  = 14'h0200;
  localparam logic [13:0] P_NIBBLE_EXCHANGE  = 14'h0E00;
  localparam logic [13:0] P_XOR_ACC_INTO_REG  = 14'h0600;

  typedef struct packed {
    logic irq_en;
    logic timeout;
    logic powerdown;
    logic zero;
    logic half_carry;
    logic carry;
  } flags_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACK    = 2'b01,
    ST_SECOND = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic [7:0] res;
    logic       wr_acc;
    logic       wr_file;
    logic       upd_z;
    logic       upd_c;
    logic       upd_dc;
    logic       c;
    logic       dc;
    logic       jump;
    logic       ret;
    logic       return_irq;
    logic       sleep;
    logic       two;
  } exec_t;
endpackage

// >>> rtl/byte_isa_execute_unit.sv
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module byte_isa_execute_unit
  import exec_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             standby,
  output logic             irq_enable
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  // pointer wraps by width, so depth must be a power of two
  if (STACK_DEPTH < 2 || STACK_DEPTH > 64 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("STACK_DEPTH out of range");
  end

  // ==========================================================
  // helpers
  function automatic logic op_is(logic [13:0] op, logic [13:0] m, logic [13:0] p);
    return (op & m) == p;
  endfunction

  // a - b with borrow-free carry and half carry
  function automatic logic [9:0] sub8(logic [7:0] a, logic [7:0] b);
    logic [8:0] full;
    logic [4:0] half;
    full = {1'b0, a} - {1'b0, b};
    half = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    return {~full[8], ~half[4], full[7:0]};
  endfunction

  // ==========================================================
  // state
  bus_state_t          state_q;
  logic [31:0]         rdata_q;
  logic                wait_q;
  logic [7:0]          acc_q;
  flags_t              flags_q;
  logic [12:0]         pc_q;
  logic [4:0]          ulatch_q;
  logic [12:0]         stack_q [STACK_DEPTH];
  logic [SP_W-1:0]     sp_q;
  logic [7:0]          file_q [128];
  logic [6:0]          faddr_q;
  logic [7:0]          wdog_q;
  logic [7:0]          presc_q;
  logic                standby_q;
  logic [13:0]         op_q;

  logic [13:0]         op;
  logic                wr_ok;
  logic                exe;
  logic [7:0]          fdat;
  logic [12:0]         head;
  exec_t               ex;
  logic [9:0]          sub_r;

  assign op    = writedata[13:0];
  assign wr_ok = (state_q == ST_ACK) && write && (byteenable[1:0] == 2'b11);
  assign exe   = wr_ok && (address == OFF_INSTR) && !standby_q;
  assign fdat  = file_q[op[6:0]];
  assign head  = stack_q[sp_q - SP_W'(1)];

  // ==========================================================
  // instruction decode and datapath
  always_comb begin
    ex    = '0;
    sub_r = '0;
    if (op_is(op, M_JUMP_ABSOLUTE, P_JUMP_ABSOLUTE)) begin
      ex.jump = 1'b1;
      ex.two  = 1'b1;
    end else if (op_is(op, M_HI8, P_OR_LITERAL_ACC)) begin
      ex.res    = acc_q | op[7:0];
      ex.wr_acc = 1'b1;
      ex.upd_z  = 1'b1;
    end else if (op_is(op, M_HI8, P_XOR_LITERAL_ACC)) begin
      ex.res    = acc_q ^ op[7:0];
      ex.wr_acc = 1'b1;
      ex.upd_z  = 1'b1;
    end else if (op_is(op, M_LOAD_LITERAL_ACC, P_LOAD_LITERAL_ACC)) begin
      ex.res    = op[7:0];
      ex.wr_acc = 1'b1;
    end else if (op_is(op, M_LOAD_LITERAL_ACC, P_RETURN_WITH_LITERAL)) begin
      ex.res    = op[7:0];
      ex.wr_acc = 1'b1;
      ex.ret    = 1'b1;
      ex.two    = 1'b1;
    end else if (op_is(op, M_LITERAL_MINUS_ACC, P_LITERAL_MINUS_ACC)) begin
      sub_r     = sub8(op[7:0], acc_q);
      ex.res    = sub_r[7:0];
      ex.wr_acc = 1'b1;
      {ex.c, ex.dc} = sub_r[9:8];
      {ex.upd_z, ex.upd_c, ex.upd_dc} = 3'h7;
    end else if (op_is(op, M_ALL, P_RETURN_IRQ)) begin
      ex.ret    = 1'b1;
      ex.return_irq = 1'b1;
      ex.two    = 1'b1;
    end else if (op_is(op, M_ALL, P_RETURN)) begin
      ex.ret = 1'b1;
      ex.two = 1'b1;
    end else if (op_is(op, M_ALL, P_SLEEP)) begin
      ex.sleep = 1'b1;
    end else if (op_is(op, M_STORE_ACC_REG, P_STORE_ACC_REG)) begin
      ex.res     = acc_q;
      ex.wr_file = 1'b1;
    end else if (op_is(op, M_HI8, P_INCREMENT_REG) || op_is(op, M_HI8, P_OR_ACC_INTO_REG)
                 || op_is(op, M_HI8, P_COPY_REG) || op_is(op, M_HI8, P_XOR_ACC_INTO_REG)
                 || op_is(op, M_HI8, P_REG_MINUS_ACC) || op_is(op, M_HI8, P_RLF)
                 || op_is(op, M_HI8, P_RRF) || op_is(op, M_HI8, P_NIBBLE_EXCHANGE)) begin
      // destination select for file operations
      ex.wr_acc  = !op[7];
      ex.wr_file = op[7];
      case (op[11:8])
        P_INCREMENT_REG[11:8]: begin
          ex.res   = fdat + 8'h01;
          ex.upd_z = 1'b1;
        end
        P_OR_ACC_INTO_REG[11:8]: begin
          ex.res   = fdat | acc_q;
          ex.upd_z = 1'b1;
        end
        P_COPY_REG[11:8]: begin
          ex.res   = fdat;
          ex.upd_z = 1'b1;
        end
        P_XOR_ACC_INTO_REG[11:8]: begin
          ex.res   = fdat ^ acc_q;
          ex.upd_z = 1'b1;
        end
        P_REG_MINUS_ACC[11:8]: begin
          sub_r  = sub8(fdat, acc_q);
          ex.res = sub_r[7:0];
          {ex.c, ex.dc} = sub_r[9:8];
          {ex.upd_z, ex.upd_c, ex.upd_dc} = 3'h7;
        end
        P_RLF[11:8]: begin
          ex.res   = {fdat[6:0], flags_q.carry};
          ex.c     = fdat[7];
          ex.upd_c = 1'b1;
        end
        P_RRF[11:8]: begin
          ex.res   = {flags_q.carry, fdat[7:1]};
          ex.c     = fdat[0];
          ex.upd_c = 1'b1;
        end
        default: begin
          ex.res = {fdat[3:0], fdat[7:4]};
        end
      endcase
    end
    // idle op and unlisted codes leave ex cleared
  end

  // ==========================================================
  // avalon slave handshake, second cycle of two-cycle ops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (read || write) begin
            wait_q  <= 1'b0;
            state_q <= ST_ACK;
            case (address)
              OFF_INSTR:  rdata_q <= {18'h0_0000, op_q};
              OFF_ACC:    rdata_q <= {24'h00_0000, acc_q};
              OFF_STATUS: rdata_q <= {25'h000_0000, standby_q, flags_q};
              OFF_PC:     rdata_q <= {19'h0_0000, pc_q};
              OFF_ULATCH: rdata_q <= {27'h000_0000, ulatch_q};
              OFF_STACK:  rdata_q <= {19'h0_0000, head};
              OFF_FADDR:  rdata_q <= {25'h000_0000, faddr_q};
              OFF_FDATA:  rdata_q <= {24'h00_0000, file_q[faddr_q]};
              OFF_WDOG:   rdata_q <= {24'h00_0000, wdog_q};
              default:    rdata_q <= 32'h0000_0000;
            endcase
          end
        end
        ST_ACK: begin
          wait_q  <= 1'b1;
          state_q <= (exe && ex.two) ? ST_SECOND : ST_IDLE;
        end
        ST_SECOND: state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // accumulator
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 8'h00;
    end else if (exe && ex.wr_acc) begin
      acc_q <= ex.res;
    end else if (wr_ok && address == OFF_ACC) begin
      acc_q <= writedata[7:0];
    end
  end

  // ==========================================================
  // status flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= FLAGS_RST;
    end else if (exe) begin
      if (ex.upd_z) flags_q.zero <= (ex.res == 8'h00);
      if (ex.upd_c) flags_q.carry <= ex.c;
      if (ex.upd_dc) flags_q.half_carry <= ex.dc;
      if (ex.return_irq) flags_q.irq_en <= 1'b1;
      if (ex.sleep) begin
        flags_q.timeout   <= 1'b1;
        flags_q.powerdown <= 1'b0;
      end
    end else if (wr_ok && address == OFF_STATUS) begin
      flags_q <= writedata[5:0];
    end else if (wdog_q == 8'hFF && presc_q == 8'(WDOG_PRESC_DIV - 1)) begin
      flags_q.timeout <= 1'b0; // watchdog expired
    end
  end

  // ==========================================================
  // program counter and opcode capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= 13'h0000;
      op_q <= 14'h0000;
    end else if (exe) begin
      op_q <= op;
      if (ex.jump) pc_q <= {ulatch_q[ULATCH_HI:ULATCH_LO], op[10:0]};
      else if (ex.ret) pc_q <= head;
      else pc_q <= pc_q + 13'h0001;
    end else if (wr_ok && address == OFF_PC) begin
      pc_q <= writedata[12:0];
    end
  end

  // ==========================================================
  // return stack: bus write pushes, return pops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sp_q <= '0;
    end else if (exe && ex.ret) begin
      sp_q <= sp_q - SP_W'(1);
    end else if (wr_ok && address == OFF_STACK) begin
      sp_q <= sp_q + SP_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (wr_ok && address == OFF_STACK && !exe) begin
      stack_q[sp_q] <= writedata[12:0];
    end
  end

  // ==========================================================
  // upper-address latch and file pointer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ulatch_q <= 5'h00;
      faddr_q  <= 7'h00;
    end else if (wr_ok) begin
      if (address == OFF_ULATCH) ulatch_q <= writedata[4:0];
      if (address == OFF_FADDR) faddr_q <= writedata[6:0];
    end
  end

  // ==========================================================
  // data register file
  always_ff @(posedge clock) begin
    if (exe && ex.wr_file) begin
      file_q[op[6:0]] <= ex.res;
    end else if (wr_ok && address == OFF_FDATA) begin
      file_q[faddr_q] <= writedata[7:0];
    end
  end

  // ==========================================================
  // watchdog counter with prescaler
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wdog_q  <= 8'h00;
      presc_q <= 8'h00;
    end else if (exe && ex.sleep) begin
      wdog_q  <= 8'h00;
      presc_q <= 8'h00;
    end else if (presc_q == 8'(WDOG_PRESC_DIV - 1)) begin
      presc_q <= 8'h00;
      wdog_q  <= wdog_q + 8'h01;
    end else begin
      presc_q <= presc_q + 8'h01;
    end
  end

  // ==========================================================
  // standby: halts execution until status is written with bit 6 clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      standby_q <= 1'b0;
    end else if (exe && ex.sleep) begin
      standby_q <= 1'b1;
    end else if (wr_ok && address == OFF_STATUS) begin
      standby_q <= writedata[STAT_STANDBY_BIT];
    end
  end

  assign readdata    = rdata_q;
  assign waitrequest = wait_q;
  assign standby     = standby_q;
  assign irq_enable  = flags_q.irq_en;

  // ==========================================================
  // checks
  AST_JUMP_TARGET: assert property (@(posedge clock) disable iff (!rst_n)
    exe && op_is(op, M_JUMP_ABSOLUTE, P_JUMP_ABSOLUTE) |=>
      pc_q == {$past(ulatch_q[4:3]), $past(writedata[10:0])})
    else $error("jump target wrong");
  AST_JUMP_TWO: assert property (@(posedge clock) disable iff (!rst_n)
    exe && op_is(op, M_JUMP_ABSOLUTE, P_JUMP_ABSOLUTE) |=>
      state_q == ST_SECOND && wait_q ##1 state_q == ST_IDLE)
    else $error("jump not two cycles");
  AST_OR_LIT: assert property (@(posedge clock) disable iff (!rst_n)
    exe && op_is(op, M_HI8, P_OR_LITERAL_ACC) |=>
      acc_q == ($past(acc_q) | $past(writedata[7:0]))
      && flags_q.zero == (acc_q == 8'h00) && flags_q.carry == $past(flags_q.carry))
    else $error("or literal wrong");
  AST_LOAD_FLAGS: assert property (@(posedge clock) disable iff (!rst_n)
    exe && op_is(op, M_LOAD_LITERAL_ACC, P_LOAD_LITERAL_ACC) |=>
      acc_q == $past(writedata[7:0]) && $stable(flags_q))
    else $error("load literal wrong");
  AST_IRQ_RETURN: assert property (@(posedge clock) disable iff (!rst_n)
    exe && op_is(op, M_ALL, P_RETURN_IRQ) |=>
      irq_enable && pc_q == $past(head) && sp_q == $past(sp_q) - SP_W'(1))
    else $error("irq return wrong");
  AST_STANDBY: assert property (@(posedge clock) disable iff (!rst_n)
    exe && op_is(op, M_ALL, P_SLEEP) |=>
      standby && flags_q.timeout && !flags_q.powerdown && wdog_q == 8'h00)
    else $error("standby entry wrong");
  AST_STORE: assert property (@(posedge clock) disable iff (!rst_n)
    exe && op_is(op, M_STORE_ACC_REG, P_STORE_ACC_REG) |=>
      file_q[$past(writedata[6:0])] == $past(acc_q) && $stable(flags_q))
    else $error("store accumulator wrong");
  AST_IDLE_OP: assert property (@(posedge clock) disable iff (!rst_n)
    exe && op_is(op, M_NOP, P_NOP) |=>
      $stable(acc_q) && $stable(flags_q) && pc_q == $past(pc_q) + 13'h0001)
    else $error("idle op changed state");
  AST_RLF: assert property (@(posedge clock) disable iff (!rst_n)
    exe && op_is(op, M_HI8, P_RLF) && !op[7] |=>
      acc_q == {$past(fdat[6:0]), $past(flags_q.carry)} && flags_q.carry == $past(fdat[7]))
    else $error("rotate left wrong");
endmodule

// >>> bench/avalon_host_model.sv
`timescale 1ns/10ps
// ==========================================================
// host side: avalon master standing in for software
module avalon_host_model (
  input  wire logic        clock,
  output logic      [5:0]  address,
  output logic             read,
  output logic             write,
  output logic      [3:0]  byteenable,
  output logic      [31:0] writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  // idle bus from time zero
  initial begin
    address    = 6'h00;
    read       = 1'b0;
    write      = 1'b0;
    byteenable = 4'hF;
    writedata  = 32'h0;
  end

  // one transfer, held until waitrequest is sampled low
  task automatic xfer(input logic [5:0] a, input logic w, input logic [3:0] be,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    address    <= a;
    read       <= !w;
    write      <= w;
    byteenable <= be;
    writedata  <= d;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata; // read data taken at the ack edge only
    read  <= 1'b0;
    write <= 1'b0;
  endtask
endmodule

// >>> bench/byte_isa_execute_unit_tb_top.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("FAIL %0t got %h exp %h", $time, (got), (exp)); \
  end \
end

module byte_isa_execute_unit_tb_top;
  import exec_pkg::*;
  logic        clock;
  logic        rst_n;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        standby;
  logic        irq_enable;
  logic [31:0] q;
  int          miscompares;
  int          comparisons;

  // ==========================================================
  // structure
  byte_isa_execute_unit #(.STACK_DEPTH(8)) i_dut (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .standby(standby), .irq_enable(irq_enable)
  );

  avalon_host_model i_host (
    .clock(clock), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest)
  );

  // ==========================================================
  // bus helpers
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    i_host.xfer(a, 1'b1, 4'hF, d, q);
  endtask

  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    i_host.xfer(a, 1'b0, 4'hF, 32'h0, q);
    `CHK(q, e)
  endtask

  task automatic op(input logic [13:0] o);
    wr(OFF_INSTR, {18'h0, o});
  endtask

  // file op on register 0x21: preset acc, flags, file; check all three
  task automatic fcase(input logic [13:0] p, input logic d,
                       input logic [7:0] fv, av, st, res, se);
    wr(OFF_ACC, {24'h0, av});
    wr(OFF_STATUS, {24'h0, st});
    wr(OFF_FADDR, 32'h21);
    wr(OFF_FDATA, {24'h0, fv});
    op(p | {6'h0, d, 7'h21});
    rc(OFF_ACC, {24'h0, d ? av : res});
    rc(OFF_FDATA, {24'h0, d ? res : fv});
    rc(OFF_STATUS, {24'h0, se});
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rc(OFF_STATUS, 32'h18);
    rc(OFF_ACC, 32'h0);
    rc(OFF_PC, 32'h0);
    `CHK(standby, 1'b0)
    `CHK(irq_enable, 1'b0)
  endtask

  task automatic t_literals();
    wr(OFF_STATUS, 32'h07);
    op(P_LOAD_LITERAL_ACC | 14'h005A);
    rc(OFF_ACC, 32'h5A);
    rc(OFF_STATUS, 32'h07);
    op(P_OR_LITERAL_ACC | 14'h00A5);
    rc(OFF_ACC, 32'hFF);
    rc(OFF_STATUS, 32'h03);
    op(P_XOR_LITERAL_ACC | 14'h00FF);
    rc(OFF_ACC, 32'h00);
    rc(OFF_STATUS, 32'h07);
    op(P_XOR_LITERAL_ACC | 14'h000F);
    rc(OFF_ACC, 32'h0F);
    rc(OFF_STATUS, 32'h03);
  endtask

  task automatic t_sub_literal();
    logic [7:0] k [4] = '{8'h05, 8'h03, 8'h10, 8'h20};
    logic [7:0] w [4] = '{8'h03, 8'h05, 8'h01, 8'h20};
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      r = k[i] - w[i];
      wr(OFF_ACC, {24'h0, w[i]});
      wr(OFF_STATUS, 32'h0);
      op(P_LITERAL_MINUS_ACC | {6'h0, k[i]});
      rc(OFF_ACC, {24'h0, r});
      rc(OFF_STATUS, {29'h0, r == 8'h00, k[i][3:0] >= w[i][3:0], k[i] >= w[i]});
    end
  endtask

  task automatic t_file_ops();
    fcase(P_INCREMENT_REG, 1'b1, 8'hFF, 8'h12, 8'h00, 8'h00, 8'h04);
    fcase(P_INCREMENT_REG, 1'b0, 8'h41, 8'h12, 8'h04, 8'h42, 8'h00);
    fcase(P_OR_ACC_INTO_REG, 1'b0, 8'h0F, 8'h30, 8'h04, 8'h3F, 8'h00);
    fcase(P_OR_ACC_INTO_REG, 1'b1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04);
    fcase(P_COPY_REG, 1'b1, 8'h00, 8'h55, 8'h00, 8'h00, 8'h04);
    fcase(P_COPY_REG, 1'b0, 8'h80, 8'h55, 8'h04, 8'h80, 8'h00);
    fcase(P_XOR_ACC_INTO_REG, 1'b1, 8'hAA, 8'hAA, 8'h00, 8'h00, 8'h04);
    fcase(P_XOR_ACC_INTO_REG, 1'b0, 8'hF0, 8'h0F, 8'h04, 8'hFF, 8'h00);
    fcase(P_REG_MINUS_ACC, 1'b0, 8'h10, 8'h01, 8'h06, 8'h0F, 8'h01);
    fcase(P_REG_MINUS_ACC, 1'b1, 8'h01, 8'h02, 8'h07, 8'hFF, 8'h00);
    fcase(P_REG_MINUS_ACC, 1'b1, 8'h3C, 8'h3C, 8'h00, 8'h00, 8'h07);
    fcase(P_RLF, 1'b0, 8'h81, 8'h00, 8'h00, 8'h02, 8'h01);
    fcase(P_RLF, 1'b1, 8'h40, 8'h00, 8'h05, 8'h81, 8'h04);
    fcase(P_RRF, 1'b0, 8'h01, 8'h00, 8'h01, 8'h80, 8'h01);
    fcase(P_RRF, 1'b1, 8'h02, 8'h00, 8'h04, 8'h01, 8'h04);
    fcase(P_NIBBLE_EXCHANGE, 1'b1, 8'hA5, 8'h00, 8'h07, 8'h5A, 8'h07);
    fcase(P_NIBBLE_EXCHANGE, 1'b0, 8'h0F, 8'h00, 8'h00, 8'hF0, 8'h00);
    fcase(P_STORE_ACC_REG, 1'b1, 8'h00, 8'h3C, 8'h07, 8'h3C, 8'h07);
  endtask

  task automatic t_jump();
    wr(OFF_ULATCH, 32'h18);
    op(P_JUMP_ABSOLUTE | 14'h07FF);
    rc(OFF_PC, 32'h1FFF);
    wr(OFF_ULATCH, 32'h17);
    op(P_JUMP_ABSOLUTE | 14'h0000);
    rc(OFF_PC, 32'h1000);
  endtask

  task automatic t_returns();
    wr(OFF_STATUS, 32'h07);
    wr(OFF_STACK, 32'h0123);
    wr(OFF_STACK, 32'h0321);
    op(P_RETURN);
    rc(OFF_PC, 32'h0321);
    op(P_RETURN);
    rc(OFF_PC, 32'h0123);
    rc(OFF_STATUS, 32'h07);
    wr(OFF_STACK, 32'h0456);
    op(P_RETURN_WITH_LITERAL | 14'h0099);
    rc(OFF_PC, 32'h0456);
    rc(OFF_ACC, 32'h99);
    rc(OFF_STATUS, 32'h07);
    wr(OFF_STATUS, 32'h00);
    wr(OFF_STACK, 32'h1ABC);
    op(P_RETURN_IRQ);
    rc(OFF_PC, 32'h1ABC);
    rc(OFF_STATUS, 32'h20);
    `CHK(irq_enable, 1'b1)
  endtask

  task automatic t_idle();
    wr(OFF_ACC, 32'h77);
    wr(OFF_STATUS, 32'h05);
    wr(OFF_PC, 32'h0010);
    op(P_NOP);
    rc(OFF_PC, 32'h0011);
    rc(OFF_ACC, 32'h77);
    rc(OFF_STATUS, 32'h05);
  endtask

  task automatic t_standby();
    wr(OFF_ACC, 32'h44);
    wr(OFF_STATUS, 32'h00);
    repeat (600) @(posedge clock);
    op(P_SLEEP);
    rc(OFF_STATUS, 32'h50);
    `CHK(standby, 1'b1)
    rc(OFF_WDOG, 32'h0);
    op(P_LOAD_LITERAL_ACC | 14'h0033);
    rc(OFF_ACC, 32'h44);
    wr(OFF_STATUS, 32'h00);
    rc(OFF_STATUS, 32'h00);
    `CHK(standby, 1'b0)
  endtask

  task automatic t_bus_edges();
    wr(OFF_ACC, 32'h11);
    i_host.xfer(OFF_ACC, 1'b1, 4'h0, 32'hAB, q);
    rc(OFF_ACC, 32'h11);
    rc(6'h3C, 32'h0);
  endtask

  // ==========================================================
  // verdict
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // clock, 20 ns period
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // main sequence
  initial begin
    miscompares = 0;
    comparisons = 0;
    rst_n = 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_literals();
    t_sub_literal();
    t_file_ops();
    t_jump();
    t_returns();
    t_idle();
    t_standby();
    t_bus_edges();
    stop_test();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    stop_test();
  end
endmodule
